/* rtl/apa_pkg.sv */
// constants, types and decoders for the phase-adjust configuration block
// assumes one 50 MHz clock that also paces the sampled pixel stream
//
// Function
// - lines just before the frame sync leading edge are masked, code 0..7 -> 0,1,2,4,6,8,10,12 lines.
// - lines just after the frame sync leading edge are masked, code 0..7 -> 5,18,19,20,22,25,41,44 lines.
// - each pixel mask value N masks 2*N pixels, one after and one before the line sync edge.
// - options bits 0, 1, 2 drop blue, green, red from the measurement when set.
// - options bit 3 keeps the lowest-scoring phase when zero and the highest-scoring phase when one.
// - each search step lasts 28 frame syncs when bit 4 is zero and 64 when it is one.
// - options bit 5 zero applies the found phase at once, one defers it to the next frame sync.
// - options bit 6 holds the engine in reset while set; software pulses it high then low.
// - the 10-bit transition threshold is the 8-bit register value times four.
// - only pixel-to-pixel steps at or above the threshold count toward the quality score.
// - four read-only result locations exist and writes to them do nothing.
// - a write to the command register launches the command in its three low bits.
// - status bit 7 reads one while an adjustment runs and zero when idle.
package apa_pkg;
	localparam int ADR_W = 10;
	localparam int DAT_W = 32;
	localparam int PIX_W = 10;
	localparam int PH_W = 6;
	localparam int CNT_W = 12;
	localparam int SCORE_W = 32;
	// register indices, byte address is index times four
	localparam logic [7:0] IDX_CMD = 8'h50;
	localparam logic [7:0] IDX_STATUS = 8'h51;
	localparam logic [7:0] IDX_VMASK = 8'h52;
	localparam logic [7:0] IDX_HMASK_AFT = 8'h53;
	localparam logic [7:0] IDX_HMASK_BEF = 8'h54;
	localparam logic [7:0] IDX_OPT = 8'h55;
	localparam logic [7:0] IDX_THR = 8'h56;
	localparam logic [7:0] IDX_RES3 = 8'h57;
	localparam logic [7:0] IDX_RES2 = 8'h58;
	localparam logic [7:0] IDX_RES1 = 8'h59;
	localparam logic [7:0] IDX_RES0 = 8'h5A;
	// reset values
	localparam logic [7:0] RST_VMASK = 8'h01;
	localparam logic [7:0] RST_HMASK = 8'h01;
	localparam logic [7:0] RST_OPT = 8'h20;
	localparam logic [7:0] RST_THR = 8'h0A;
	// field positions
	localparam int VM_BEF_LSB = 0;
	localparam int VM_AFT_LSB = 4;
	localparam int OPT_BLUE = 0;
	localparam int OPT_GREEN = 1;
	localparam int OPT_RED = 2;
	localparam int OPT_GOAL = 3;
	localparam int OPT_SPEED = 4;
	localparam int OPT_DEFER = 5;
	localparam int OPT_SRST = 6;
	localparam int STAT_BUSY = 7;
	// commands
	localparam logic [2:0] CMD_PHASE_SEARCH = 3'h3;
	localparam logic [2:0] CMD_ACTIVE_WINDOW = 3'h4;
	// timing counts in frame sync intervals, and the last phase tried
	localparam logic [6:0] STEP_FAST = 7'h1C;
	localparam logic [6:0] STEP_SLOW = 7'h40;
	localparam logic [PH_W-1:0] PH_LAST = 6'h3F;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [ADR_W-1:0] adr;
		logic [3:0] sel;
		logic [DAT_W-1:0] dat;
	} apa_wb_req_t;

	typedef struct packed {
		logic ack;
		logic [DAT_W-1:0] dat;
	} apa_wb_rsp_t;

	typedef struct packed {
		logic [PIX_W-1:0] red;
		logic [PIX_W-1:0] green;
		logic [PIX_W-1:0] blue;
	} apa_pix_t;

	function automatic logic [CNT_W-1:0] lines_before(input logic [2:0] c);
		case (c)
			3'h0: lines_before = 12'h000;
			3'h1: lines_before = 12'h001;
			3'h2: lines_before = 12'h002;
			3'h3: lines_before = 12'h004;
			3'h4: lines_before = 12'h006;
			3'h5: lines_before = 12'h008;
			3'h6: lines_before = 12'h00A;
			default: lines_before = 12'h00C;
		endcase
	endfunction : lines_before

	function automatic logic [CNT_W-1:0] lines_after(input logic [2:0] c);
		case (c)
			3'h0: lines_after = 12'h005;
			3'h1: lines_after = 12'h012;
			3'h2: lines_after = 12'h013;
			3'h3: lines_after = 12'h014;
			3'h4: lines_after = 12'h016;
			3'h5: lines_after = 12'h019;
			3'h6: lines_after = 12'h029;
			default: lines_after = 12'h02C;
		endcase
	endfunction : lines_after
endpackage : apa_pkg

/* rtl/apa_trans_det.sv */
// per-pixel transition detector over the three colour channels
// assumes pixels arrive already synchronised, one per clock
`timescale 1ns/100ps
`default_nettype none
module apa_trans_det (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire apa_pkg::apa_pix_t pix_i,
	input wire logic [2:0] chan_off_i,
	input wire logic [7:0] thr_i,
	input wire logic gate_i,
	output logic [1:0] count_o
);
	import apa_pkg::*;

	typedef struct packed {
		apa_pix_t prev;
		logic [1:0] count;
	} apa_td_state_t;

	apa_td_state_t s_r;
	apa_td_state_t s_nxt;
	logic [PIX_W-1:0] thr10;
	logic [PIX_W-1:0] cur [3];
	logic [PIX_W-1:0] old [3];
	logic [2:0] hit;

	assign thr10 = {thr_i, 2'b00};
	assign cur[0] = pix_i.blue;
	assign cur[1] = pix_i.green;
	assign cur[2] = pix_i.red;
	assign old[0] = s_r.prev.blue;
	assign old[1] = s_r.prev.green;
	assign old[2] = s_r.prev.red;

	// ----------------------------------------
	// per channel step compare
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_chan
			logic [PIX_W-1:0] diff;
			assign diff = (cur[g] >= old[g]) ? cur[g] - old[g] : old[g] - cur[g];
			assign hit[g] = ~chan_off_i[g] & (diff >= thr10);
		end
	endgenerate

	always_comb begin
		s_nxt = s_r;
		s_nxt.prev = pix_i;
		s_nxt.count = gate_i ? (2'(hit[0]) + 2'(hit[1]) + 2'(hit[2]))
			: 2'h0;
		if (rst_i) begin
			s_nxt = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		s_r <= s_nxt;
	end

	assign count_o = s_r.count;
endmodule : apa_trans_det
`default_nettype wire

/* rtl/apa_config.sv */
// phase-adjust configuration registers and sampling-phase search engine
// assumes a classic wishbone master and sync/pixel pins sampled on clk_i
`timescale 1ns/100ps
`default_nettype none
module apa_config (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire apa_pkg::apa_wb_req_t wb_req_i,
	output apa_pkg::apa_wb_rsp_t wb_rsp_o,
	input wire logic frame_sync_i,
	input wire logic line_sync_output_i,
	input wire apa_pkg::apa_pix_t pix_i,
	output logic [apa_pkg::PH_W-1:0] phase_o,
	output logic active_window_command_o,
	output logic phase_engine_active_o
);
	import apa_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_MEASURE = 2'b01,
		ST_APPLY = 2'b10
	} apa_state_t;

	typedef struct packed {
		logic [7:0] vmask;
		logic [7:0] hmask_aft;
		logic [7:0] hmask_bef;
		logic [7:0] opt;
		logic [7:0] thr;
		logic ack;
		logic [7:0] rdat;
		logic [1:0] vs_s;
		logic vs_d;
		logic [1:0] hs_s;
		logic hs_d;
		apa_pix_t pix_s0;
		apa_pix_t pix_s1;
		logic [CNT_W-1:0] line_cnt;
		logic [CNT_W-1:0] frame_lines;
		logic [CNT_W-1:0] pix_cnt;
		logic [CNT_W-1:0] line_len;
		apa_state_t state;
		logic busy;
		logic win_pulse;
		logic [PH_W-1:0] phase_cur;
		logic [PH_W-1:0] phase_try;
		logic [PH_W-1:0] best_phase;
		logic first;
		logic [SCORE_W-1:0] score;
		logic [SCORE_W-1:0] best_score;
		logic [6:0] vs_cnt;
	} apa_cfg_state_t;

	apa_cfg_state_t s_r;
	apa_cfg_state_t s_nxt;
	logic [1:0] trans_cnt;
	logic collect;

	// ----------------------------------------
	// register read decode
	// ----------------------------------------
	function automatic logic [7:0] rd_mux(input apa_cfg_state_t s,
		input logic [7:0] idx);
		case (idx)
			IDX_STATUS: rd_mux = {s.busy, 7'h00};
			IDX_VMASK: rd_mux = s.vmask;
			IDX_HMASK_AFT: rd_mux = s.hmask_aft;
			IDX_HMASK_BEF: rd_mux = s.hmask_bef;
			IDX_OPT: rd_mux = s.opt;
			IDX_THR: rd_mux = s.thr;
			IDX_RES3: rd_mux = s.best_score[31:24];
			IDX_RES2: rd_mux = s.best_score[23:16];
			IDX_RES1: rd_mux = s.best_score[15:8];
			IDX_RES0: rd_mux = s.best_score[7:0];
			default: rd_mux = 8'h00;
		endcase
	endfunction : rd_mux

	// ----------------------------------------
	// mask window
	// ----------------------------------------
	logic [CNT_W-1:0] vbef;
	logic [CNT_W-1:0] vaft;
	logic [CNT_W-1:0] haft;
	logic [CNT_W-1:0] hbef;
	logic v_masked;
	logic h_masked;

	assign vbef = lines_before(s_r.vmask[VM_BEF_LSB +: 3]);
	assign vaft = lines_after(s_r.vmask[VM_AFT_LSB +: 3]);
	assign haft = {3'h0, s_r.hmask_aft, 1'b0};
	assign hbef = {3'h0, s_r.hmask_bef, 1'b0};
	assign v_masked = (s_r.line_cnt < vaft)
		|| (13'(s_r.line_cnt) + 13'(vbef) >= 13'(s_r.frame_lines));
	assign h_masked = (s_r.pix_cnt < haft)
		|| (13'(s_r.pix_cnt) + 13'(hbef) >= 13'(s_r.line_len));
	assign collect = (s_r.state == ST_MEASURE) && !v_masked && !h_masked;

	apa_trans_det u_trans (
		.clk_i(clk_i),
		.rst_i(rst_i | s_r.opt[OPT_SRST]),
		.pix_i(s_r.pix_s1),
		.chan_off_i(s_r.opt[OPT_RED:OPT_BLUE]),
		.thr_i(s_r.thr),
		.gate_i(collect),
		.count_o(trans_cnt)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	logic [7:0] idx;
	logic commit;
	logic vs_edge;
	logic hs_edge;
	logic cmd_wr;
	logic [6:0] step_len;
	logic better;

	assign idx = wb_req_i.adr[ADR_W-1:2];
	assign commit = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & s_r.ack
		& wb_req_i.sel[0];
	assign vs_edge = s_r.vs_s[1] & ~s_r.vs_d;
	assign hs_edge = s_r.hs_s[1] & ~s_r.hs_d;
	assign cmd_wr = commit && (idx == IDX_CMD);
	assign step_len = s_r.opt[OPT_SPEED] ? STEP_SLOW : STEP_FAST;
	assign better = s_r.opt[OPT_GOAL] ? (s_r.score > s_r.best_score)
		: (s_r.score < s_r.best_score);

	always_comb begin
		s_nxt = s_r;
		// bus slave: answer one cycle after the request
		s_nxt.ack = wb_req_i.cyc & wb_req_i.stb & ~s_r.ack;
		if (wb_req_i.cyc & wb_req_i.stb & ~s_r.ack) begin
			s_nxt.rdat = rd_mux(s_r, idx);
		end
		if (commit) begin
			case (idx)
				IDX_VMASK: s_nxt.vmask = wb_req_i.dat[7:0];
				IDX_HMASK_AFT: s_nxt.hmask_aft = wb_req_i.dat[7:0];
				IDX_HMASK_BEF: s_nxt.hmask_bef = wb_req_i.dat[7:0];
				IDX_OPT: s_nxt.opt = wb_req_i.dat[7:0];
				IDX_THR: s_nxt.thr = wb_req_i.dat[7:0];
				default: s_nxt.thr = s_r.thr;
			endcase
		end
		// pin synchronisers
		s_nxt.vs_s = {s_r.vs_s[0], frame_sync_i};
		s_nxt.vs_d = s_r.vs_s[1];
		s_nxt.hs_s = {s_r.hs_s[0], line_sync_output_i};
		s_nxt.hs_d = s_r.hs_s[1];
		s_nxt.pix_s0 = pix_i;
		s_nxt.pix_s1 = s_r.pix_s0;
		// line and pixel position
		s_nxt.pix_cnt = s_r.pix_cnt + 12'h001;
		if (hs_edge) begin
			s_nxt.pix_cnt = 12'h000;
			s_nxt.line_len = s_r.pix_cnt;
			s_nxt.line_cnt = s_r.line_cnt + 12'h001;
		end
		if (vs_edge) begin
			s_nxt.line_cnt = 12'h000;
			s_nxt.frame_lines = s_r.line_cnt;
		end
		// search engine
		s_nxt.win_pulse = cmd_wr
			&& (wb_req_i.dat[2:0] == CMD_ACTIVE_WINDOW);
		case (s_r.state)
			ST_IDLE: begin
				if (cmd_wr && (wb_req_i.dat[2:0] == CMD_PHASE_SEARCH)) begin
					s_nxt.state = ST_MEASURE;
					s_nxt.busy = 1'b1;
					s_nxt.phase_try = '0;
					s_nxt.phase_cur = '0;
					s_nxt.score = '0;
					s_nxt.vs_cnt = 7'h00;
					s_nxt.first = 1'b1;
				end
			end
			ST_MEASURE: begin
				s_nxt.score = s_r.score + 32'(trans_cnt);
				if (vs_edge) begin
					s_nxt.vs_cnt = s_r.vs_cnt + 7'h01;
					if (s_r.vs_cnt + 7'h01 >= step_len) begin
						if (s_r.first || better) begin
							s_nxt.best_score = s_r.score;
							s_nxt.best_phase = s_r.phase_try;
						end
						s_nxt.first = 1'b0;
						s_nxt.score = '0;
						s_nxt.vs_cnt = 7'h00;
						if (s_r.phase_try == PH_LAST) begin
							s_nxt.state = ST_APPLY;
						end else begin
							s_nxt.phase_try = s_r.phase_try + 6'h01;
							s_nxt.phase_cur = s_r.phase_try + 6'h01;
						end
					end
				end
			end
			ST_APPLY: begin
				if (!s_r.opt[OPT_DEFER] || vs_edge) begin
					s_nxt.phase_cur = s_r.best_phase;
					s_nxt.busy = 1'b0;
					s_nxt.state = ST_IDLE;
				end
			end
			default: begin
				s_nxt.state = ST_IDLE;
				s_nxt.busy = 1'b0;
			end
		endcase
		// soft reset holds the engine only
		if (s_r.opt[OPT_SRST]) begin
			s_nxt.state = ST_IDLE;
			s_nxt.busy = 1'b0;
			s_nxt.win_pulse = 1'b0;
			s_nxt.phase_try = '0;
			s_nxt.best_phase = '0;
			s_nxt.first = 1'b0;
			s_nxt.score = '0;
			s_nxt.best_score = '0;
			s_nxt.vs_cnt = 7'h00;
		end
		if (rst_i) begin
			s_nxt = '0;
			s_nxt.state = ST_IDLE;
			s_nxt.vmask = RST_VMASK;
			s_nxt.hmask_aft = RST_HMASK;
			s_nxt.hmask_bef = RST_HMASK;
			s_nxt.opt = RST_OPT;
			s_nxt.thr = RST_THR;
		end
	end

	always_ff @(posedge clk_i) begin
		s_r <= s_nxt;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign wb_rsp_o.ack = s_r.ack;
	assign wb_rsp_o.dat = {24'h000000, s_r.rdat};
	assign phase_o = s_r.phase_cur;
	assign active_window_command_o = s_r.win_pulse;
	assign phase_engine_active_o = s_r.busy;
endmodule : apa_config
`default_nettype wire

/* sim/apa_config_assertions.sv */
// checker for the phase-adjust configuration block
// assumes it is bound to apa_config from the bench top
`timescale 1ns/100ps
`default_nettype none
module apa_config_assertions
	import apa_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire apa_pkg::apa_wb_req_t wb_req_i,
	input wire apa_pkg::apa_wb_rsp_t wb_rsp_o,
	input wire logic [apa_pkg::PH_W-1:0] phase_o,
	input wire logic active_window_command_o,
	input wire logic phase_engine_active_o
);
	// ----
	// helper logic
	// ----
	logic wr_hit;
	logic srst_r;
	assign wr_hit = wb_rsp_o.ack && wb_req_i.cyc && wb_req_i.stb
		&& wb_req_i.we && wb_req_i.sel[0];
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			srst_r <= 1'b0;
		end else if (wr_hit && wb_req_i.adr == {IDX_OPT, 2'b00}) begin
			srst_r <= wb_req_i.dat[OPT_SRST];
		end
	end
	// ----
	// properties
	// ----
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
	endsequence
	sequence s_win;
		wr_hit && wb_req_i.adr == {IDX_CMD, 2'b00}
			&& wb_req_i.dat[2:0] == CMD_ACTIVE_WINDOW;
	endsequence
	sequence s_launch;
		wr_hit && wb_req_i.adr == {IDX_CMD, 2'b00} && !srst_r
			&& wb_req_i.dat[2:0] == CMD_PHASE_SEARCH && !phase_engine_active_o;
	endsequence
	sequence s_idle2;
		!phase_engine_active_o ##1 !phase_engine_active_o;
	endsequence
	AST_ACK_NEXT: assert property (s_req |=> wb_rsp_o.ack)
		else $error("ack missing");
	AST_ACK_ONE: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
		else $error("ack too long");
	AST_RD_BYTE: assert property (wb_rsp_o.ack |-> wb_rsp_o.dat[31:8] == 24'h0)
		else $error("read upper bits set");
	AST_WIN_PULSE: assert property (s_win |-> ##[1:2] active_window_command_o)
		else $error("window pulse missing");
	AST_WIN_ONE: assert property (active_window_command_o |=> !active_window_command_o)
		else $error("window pulse too long");
	AST_BUSY_LAUNCH: assert property (s_launch |-> ##[1:2] phase_engine_active_o)
		else $error("busy not raised");
	AST_BUSY_HOLD: assert property ($rose(phase_engine_active_o) && !srst_r |-> phase_engine_active_o[*8])
		else $error("search ended early");
	AST_SRST: assert property (srst_r[*2] |-> !phase_engine_active_o)
		else $error("busy under soft reset");
	AST_PHASE_IDLE: assert property (s_idle2 |-> $stable(phase_o))
		else $error("phase moved while idle");
endmodule : apa_config_assertions
`default_nettype wire

/* sim/apa_config_bench.sv */
// self-checking bench for the phase-adjust configuration block
// assumes package, design and checker are compiled before this file
`timescale 1ns/100ps
`default_nettype none
module apa_config_bench;
	import apa_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	apa_wb_req_t req = '0;
	apa_wb_rsp_t rsp;
	logic fs = 1'b0;
	apa_pix_t pix = '0;
	logic [PH_W-1:0] phase;
	logic win;
	logic busy;
	logic [7:0] q;
	int n_errors = 0;
	int n_checks = 0;
	int n_win = 0;
	apa_config u_dut (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_req_i(req),
		.wb_rsp_o(rsp),
		.frame_sync_i(fs),
		.line_sync_output_i(1'b0),
		.pix_i(pix),
		.phase_o(phase),
		.active_window_command_o(win),
		.phase_engine_active_o(busy)
	);
	initial begin
		forever #10 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (win === 1'b1) n_win++;
	end
	// ----
	// shared tasks
	// ----
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wb(input logic we, input logic [7:0] idx,
		input logic [7:0] d, input logic [3:0] sel);
		int t;
		t = 0;
		@(posedge clk_i);
		req <= '{1'b1, 1'b1, we, {idx, 2'b00}, sel, {24'h0, d}};
		do begin
			@(posedge clk_i);
			t++;
		end while (rsp.ack !== 1'b1);
		q = rsp.dat[7:0];
		req <= '0;
	endtask : wb
	task automatic pulse_fs;
		fs <= 1'b1;
		repeat (4) @(posedge clk_i);
		fs <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask : pulse_fs
	task automatic wrap_up;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : wrap_up
	// ----
	// scenarios
	// ----
	task automatic t_regs;
		int i;
		logic [7:0] rv [5];
		logic [7:0] r;
		rv = '{RST_VMASK, RST_HMASK, RST_HMASK, RST_OPT, RST_THR};
		for (i = 0; i < 5; i++) begin
			wb(1'b0, 8'(IDX_VMASK + i), 8'h00, 4'h1);
			chk(32'(q), 32'(rv[i]));
			wb(1'b1, 8'(IDX_VMASK + i), 8'(8'h13 + i), 4'h1);
			wb(1'b0, 8'(IDX_VMASK + i), 8'h00, 4'h1);
			chk(32'(q), 32'(8'h13 + i));
			wb(1'b1, 8'(IDX_VMASK + i), rv[i], 4'h1);
		end
		wb(1'b1, IDX_THR, 8'hEE, 4'h0);
		wb(1'b0, IDX_THR, 8'h00, 4'h1);
		chk(32'(q), 32'(RST_THR));
		wb(1'b0, IDX_RES3, 8'h00, 4'h1);
		r = q;
		wb(1'b1, IDX_RES3, 8'hFF, 4'h1);
		wb(1'b0, IDX_RES3, 8'h00, 4'h1);
		chk(32'(q), 32'(r));
		wb(1'b0, IDX_STATUS, 8'h00, 4'h1);
		chk(32'(q), 32'h0);
		wb(1'b0, 8'hFF, 8'h00, 4'h1);
		chk(32'(q), 32'h0);
	endtask : t_regs
	task automatic t_win;
		int a;
		a = n_win;
		wb(1'b1, IDX_CMD, 8'h04, 4'h1);
		repeat (3) @(posedge clk_i);
		chk(32'(n_win - a), 32'h1);
		wb(1'b0, IDX_CMD, 8'h00, 4'h1);
		chk(32'(q), 32'h0);
	endtask : t_win
	task automatic t_srst;
		wb(1'b1, IDX_CMD, 8'h03, 4'h1);
		repeat (3) pulse_fs();
		chk(32'(busy), 32'h1);
		wb(1'b1, IDX_OPT, 8'h60, 4'h1);
		repeat (3) @(posedge clk_i);
		chk(32'(busy), 32'h0);
		wb(1'b1, IDX_OPT, 8'h20, 4'h1);
		pulse_fs();
		chk(32'(busy), 32'h0);
	endtask : t_srst
	task automatic search(input logic [7:0] opt, input int step);
		int i;
		wb(1'b1, IDX_OPT, opt, 4'h1);
		wb(1'b1, IDX_CMD, 8'h03, 4'h1);
		repeat (3) @(posedge clk_i);
		chk(32'(busy), 32'h1);
		for (i = 0; i < 64 * step; i++) begin
			pulse_fs();
			if (i % step == step / 2) chk(32'(phase), 32'(i / step));
		end
		if (opt[OPT_DEFER]) begin
			repeat (20) @(posedge clk_i);
			chk(32'(busy), 32'h1);
			pulse_fs();
		end
		chk(32'(busy), 32'h0);
		chk(32'(phase), 32'h0);
		wb(1'b0, IDX_RES0, 8'h00, 4'h1);
		chk(32'(q), 32'h0);
	endtask : search
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_win();
		t_srst();
		search(8'h20, 28);
		search(8'h18, 64);
		wrap_up();
	end
	initial begin
		repeat (80000) @(posedge clk_i);
		n_errors++;
		wrap_up();
	end
endmodule : apa_config_bench
bind apa_config apa_config_assertions u_chk (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.wb_req_i(wb_req_i),
	.wb_rsp_o(wb_rsp_o),
	.phase_o(phase_o),
	.active_window_command_o(active_window_command_o),
	.phase_engine_active_o(phase_engine_active_o)
);
`default_nettype wire
